// File: inc/ums_regs.svh
// register map, field positions and reset values of the modem status block
`ifndef UMS_REGS_SVH
`define UMS_REGS_SVH

// ----------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------
`define UMS_STAT_OFS 32'h5000_1018
`define UMS_SCR_OFS  32'h5000_101c
`define UMS_MCTL_OFS 32'h5000_1100
`define UMS_IST_OFS  32'h5000_1104
`define UMS_IMSK_OFS 32'h5000_1108

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UMS_DCD_BIT  7
`define UMS_RI_BIT   6
`define UMS_CTS_BIT  4
`define UMS_DDCD_BIT 3
`define UMS_TERI_BIT 2
`define UMS_DCTS_BIT 0
`define UMS_LOOP_BIT 4
`define UMS_USER_TWO_BIT 3
`define UMS_USER_ONE_BIT 2
`define UMS_RTS_BIT  1
`define UMS_EV_DCD   0
`define UMS_EV_RI    1
`define UMS_EV_CTS   2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UMS_SCR_RST  8'h00
`define UMS_MCTL_RST 4'h0
`define UMS_EV_RST   3'h0
`define UMS_SYNC_RST 3'h7
`define UMS_PIN_RST  1'b1
`define UMS_RD_RST   16'h0000

`endif

// File: inc/ums_pkg.sv
// shared types of the modem status block
package ums_pkg;

  typedef logic [31:0] ums_addr_t;
  typedef logic [15:0] ums_word_t;
  typedef logic [2:0]  ums_ev_t;

  // one-hot register select
  typedef enum logic [4:0] {
    UMS_SEL_NONE = 5'h00,
    UMS_SEL_STAT = 5'h01,
    UMS_SEL_SCR  = 5'h02,
    UMS_SEL_MCTL = 5'h04,
    UMS_SEL_IST  = 5'h08,
    UMS_SEL_IMSK = 5'h10
  } ums_sel_t;

endpackage : ums_pkg

// File: logic/ums_modem_status.sv
// modem status, modem control mirror and scratch registers of a uart
`timescale 1ns/1ps
`include "ums_regs.svh"
// Summary of operation
// - outside loopback, status bit 7 is inverted carrier detect input
// - outside loopback, status bit 6 is inverted ring input
// - outside loopback, status bit 4 is inverted clear-to-send input
// - in loopback, carrier status bit follows control user output two
// - in loopback, ring status bit follows control user output one
// - in loopback, clear-to-send status bit follows control rts
// - carrier change sets bit 3, cleared by status read
// - in loopback, carrier change flag tracks user output two changes
// - carrier held asserted through reset sets its change flag afterwards
// - ring going inactive sets bit 2, cleared by status read
// - in loopback, ring flag set when user output one falls
// - clear-to-send change sets bit 0, cleared by status read
// - in loopback, clear-to-send flag tracks rts changes
// - clear-to-send held asserted through reset sets its flag afterwards
// - 8-bit scratch byte stores last write, affects nothing else

module ums_modem_status (
  input  wire logic               clk,                 // 200 mhz clock
  input  wire logic               rst_b,               // async reset
  input  wire ums_pkg::ums_addr_t addr,                // register byte address
  input  wire ums_pkg::ums_word_t wdata,               // write data
  input  wire logic               wr,                  // write strobe
  input  wire logic               rd,                  // read strobe
  output logic [15:0]             rdata,               // read data, cycle after rd
  input  wire logic               dcd_in_low,          // carrier detect pin
  input  wire logic               ring_in_low,         // ring indicator pin
  input  wire logic               cts_in_low,          // clear-to-send pin
  output logic                    rts_out_low,         // request-to-send pin
  output logic                    user_output_one_low, // user output one pin
  output logic                    user_output_two_low, // user output two pin
  output logic                    irq                  // level interrupt
);
  import ums_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // shared by the write and read paths
  function automatic ums_sel_t ums_decode(input ums_addr_t a);
    case (a)
      `UMS_STAT_OFS: ums_decode = UMS_SEL_STAT;
      `UMS_SCR_OFS:  ums_decode = UMS_SEL_SCR;
      `UMS_MCTL_OFS: ums_decode = UMS_SEL_MCTL;
      `UMS_IST_OFS:  ums_decode = UMS_SEL_IST;
      `UMS_IMSK_OFS: ums_decode = UMS_SEL_IMSK;
      default:       ums_decode = UMS_SEL_NONE;
    endcase
  endfunction : ums_decode

  ums_sel_t   sel;
  logic       rd_stat;
  logic       rd_scr;
  logic       wr_scr;
  logic       wr_mctl;
  logic       wr_ist;
  logic       wr_imsk;

  // strobes qualified by the decoded register
  assign sel     = ums_decode(addr);
  assign rd_stat = rd && (sel == UMS_SEL_STAT);
  assign rd_scr  = rd && (sel == UMS_SEL_SCR);
  assign wr_scr  = wr && (sel == UMS_SEL_SCR);
  assign wr_mctl = wr && (sel == UMS_SEL_MCTL);
  assign wr_ist  = wr && (sel == UMS_SEL_IST);
  assign wr_imsk = wr && (sel == UMS_SEL_IMSK);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0]  sync1_r;  // {dcd, ri, cts}, active low
  logic [2:0]  sync2_r;
  logic [4:1]  mctl_r;   // loop, user two, user one, rts
  logic [7:0]  scr_r;
  ums_ev_t     prev_r;   // last seen status levels
  ums_ev_t     delta_r;  // change flags
  ums_ev_t     delta_nxt;
  ums_ev_t     ist_r;
  ums_ev_t     ist_nxt;
  ums_ev_t     imsk_r;
  logic [15:0] rdata_r;
  logic        rts_low_r;
  logic        user_one_low_r;
  logic        user_two_low_r;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------

  // reset to inactive so a carrier or clear-to-send line held low through reset is seen as a change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= `UMS_SYNC_RST;
      sync2_r <= `UMS_SYNC_RST;
    end else begin
      sync1_r <= {dcd_in_low, ring_in_low, cts_in_low};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // current status levels, active high
  // ----------------------------------------------------------------
  logic    lb;
  ums_ev_t lvl;  // indexed by event bit

  assign lb = mctl_r[`UMS_LOOP_BIT];

  // loopback swaps the pins for the control bits
  always_comb begin
    if (lb) begin
      lvl[`UMS_EV_DCD] = mctl_r[`UMS_USER_TWO_BIT];
      lvl[`UMS_EV_RI]  = mctl_r[`UMS_USER_ONE_BIT];
      lvl[`UMS_EV_CTS] = mctl_r[`UMS_RTS_BIT];
    end else begin
      lvl[`UMS_EV_DCD] = ~sync2_r[2];
      lvl[`UMS_EV_RI]  = ~sync2_r[1];
      lvl[`UMS_EV_CTS] = ~sync2_r[0];
    end
  end

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  ums_ev_t ev;

  // ring flags only the trailing edge, the others any edge
  assign ev[`UMS_EV_DCD] = lvl[`UMS_EV_DCD] ^ prev_r[`UMS_EV_DCD];
  assign ev[`UMS_EV_RI]  = prev_r[`UMS_EV_RI] & ~lvl[`UMS_EV_RI];
  assign ev[`UMS_EV_CTS] = lvl[`UMS_EV_CTS] ^ prev_r[`UMS_EV_CTS];

  // prev resets inactive: a carrier or clear-to-send line asserted through reset shows up as an edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= `UMS_EV_RST;
    end else begin
      prev_r <= lvl;
    end
  end

  // ----------------------------------------------------------------
  // change flags
  // ----------------------------------------------------------------

  // set beats the read clear, so an edge in the read cycle is kept
  assign delta_nxt = (delta_r & {3{~rd_stat}}) | ev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delta_r <= `UMS_EV_RST;
    end else begin
      delta_r <= delta_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------

  // write one to clear; a new event in the same cycle wins
  assign ist_nxt = (ist_r & ~({3{wr_ist}} & wdata[2:0])) | ev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ist_r <= `UMS_EV_RST;
    end else begin
      ist_r <= ist_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      imsk_r <= `UMS_EV_RST;
    end else if (wr_imsk) begin
      imsk_r <= wdata[2:0];
    end
  end

  // level output, follows the registered status and mask
  assign irq = |(ist_r & imsk_r);

  // ----------------------------------------------------------------
  // modem control and scratch
  // ----------------------------------------------------------------

  // only bits 4:1 are stored; bit 0 reads as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mctl_r <= `UMS_MCTL_RST;
    end else if (wr_mctl) begin
      mctl_r <= wdata[4:1];
    end
  end

  // upper byte is not stored at all
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scr_r <= `UMS_SCR_RST;
    end else if (wr_scr) begin
      scr_r <= wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // modem output pins
  // ----------------------------------------------------------------

  // loopback parks the pins inactive so the modem sees nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_low_r      <= `UMS_PIN_RST;
      user_one_low_r <= `UMS_PIN_RST;
      user_two_low_r <= `UMS_PIN_RST;
    end else begin
      rts_low_r      <= lb | ~mctl_r[`UMS_RTS_BIT];
      user_one_low_r <= lb | ~mctl_r[`UMS_USER_ONE_BIT];
      user_two_low_r <= lb | ~mctl_r[`UMS_USER_TWO_BIT];
    end
  end

  assign rts_out_low         = rts_low_r;
  assign user_output_one_low = user_one_low_r;
  assign user_output_two_low = user_two_low_r;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;

  // unmapped addresses and reserved bits read zero
  always_comb begin
    rd_mux = 16'h0000;
    case (sel)
      UMS_SEL_STAT: begin
        rd_mux[`UMS_DCD_BIT]  = lvl[`UMS_EV_DCD];
        rd_mux[`UMS_RI_BIT]   = lvl[`UMS_EV_RI];
        rd_mux[`UMS_CTS_BIT]  = lvl[`UMS_EV_CTS];
        rd_mux[`UMS_DDCD_BIT] = delta_r[`UMS_EV_DCD];
        rd_mux[`UMS_TERI_BIT] = delta_r[`UMS_EV_RI];
        rd_mux[`UMS_DCTS_BIT] = delta_r[`UMS_EV_CTS];
      end
      UMS_SEL_SCR:  rd_mux[7:0] = scr_r;
      UMS_SEL_MCTL: rd_mux[4:1] = mctl_r;
      UMS_SEL_IST:  rd_mux[2:0] = ist_r;
      UMS_SEL_IMSK: rd_mux[2:0] = imsk_r;
      default:      rd_mux = 16'h0000;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `UMS_RD_RST;
    end else if (rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= `UMS_RD_RST;
    end
  end

  assign rdata = rdata_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_dcd_level;
    rd_stat && !lb |=> rdata_r[7] == !$past(sync2_r[2]);
  endproperty
  a_dcd_level: assert property (p_dcd_level) else $error("carrier level wrong");

  property p_ri_level;
    rd_stat && !lb |=> rdata_r[6] == !$past(sync2_r[1]);
  endproperty
  a_ri_level: assert property (p_ri_level) else $error("ring level wrong");

  property p_cts_level;
    rd_stat && !lb |=> rdata_r[4] == !$past(sync2_r[0]);
  endproperty
  a_cts_level: assert property (p_cts_level) else $error("cts level wrong");

  property p_lb_dcd;
    rd_stat && lb |=> rdata_r[7] == $past(mctl_r[3]);
  endproperty
  a_lb_dcd: assert property (p_lb_dcd) else $error("loop carrier wrong");

  property p_lb_ri;
    rd_stat && lb |=> rdata_r[6] == $past(mctl_r[2]);
  endproperty
  a_lb_ri: assert property (p_lb_ri) else $error("loop ring wrong");

  property p_lb_cts;
    rd_stat && lb |=> rdata_r[4] == $past(mctl_r[1]);
  endproperty
  a_lb_cts: assert property (p_lb_cts) else $error("loop cts wrong");

  property p_dcd_flag;
    !lb && $stable(lb) && $changed(sync2_r[2]) |=> delta_r[0];
  endproperty
  a_dcd_flag: assert property (p_dcd_flag) else $error("carrier change lost");

  property p_dcd_clr;
    rd_stat && !ev[0] |=> !delta_r[0];
  endproperty
  a_dcd_clr: assert property (p_dcd_clr) else $error("carrier flag not cleared");

  property p_lb_dcd_flag;
    lb && $stable(lb) && $changed(mctl_r[3]) |=> delta_r[0];
  endproperty
  a_lb_dcd_flag: assert property (p_lb_dcd_flag) else $error("user two change lost");

  property p_dcd_reset;
    $rose(rst_b) && !dcd_in_low ##1 !dcd_in_low |-> ##2 delta_r[0];
  endproperty
  a_dcd_reset: assert property (p_dcd_reset) else $error("carrier reset flag");

  property p_ri_flag;
    !lb && $stable(lb) && $rose(sync2_r[1]) |=> delta_r[1];
  endproperty
  a_ri_flag: assert property (p_ri_flag) else $error("ring edge lost");

  property p_ri_only_fall;
    !lb && $stable(lb) && $fell(sync2_r[1]) && !delta_r[1] |=> !delta_r[1];
  endproperty
  a_ri_only_fall: assert property (p_ri_only_fall) else $error("ring lead edge flagged");

  property p_lb_ri_flag;
    lb && $stable(lb) && $fell(mctl_r[2]) |=> delta_r[1];
  endproperty
  a_lb_ri_flag: assert property (p_lb_ri_flag) else $error("user one fall lost");

  property p_cts_flag;
    !lb && $stable(lb) && $changed(sync2_r[0]) |=> delta_r[2];
  endproperty
  a_cts_flag: assert property (p_cts_flag) else $error("cts change lost");

  property p_lb_cts_flag;
    lb && $stable(lb) && $changed(mctl_r[1]) |=> delta_r[2];
  endproperty
  a_lb_cts_flag: assert property (p_lb_cts_flag) else $error("rts change lost");

  property p_cts_reset;
    $rose(rst_b) && !cts_in_low ##1 !cts_in_low |-> ##2 delta_r[2];
  endproperty
  a_cts_reset: assert property (p_cts_reset) else $error("cts reset flag");

  property p_scr_rw;
    wr_scr ##1 (rd_scr && !wr) |=> rdata_r[7:0] == $past(wdata[7:0], 2);
  endproperty
  a_scr_rw: assert property (p_scr_rw) else $error("scratch lost");

  property p_set_wins;
    rd_stat && (ev != 3'h0) |=> (delta_r & $past(ev)) == $past(ev);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  property p_rsvd;
    rd_stat || rd_scr |=> rdata_r[15:8] == 8'h00 && (!$past(rd_stat) || !rdata_r[5] && !rdata_r[1]);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  // main scenarios
  c_lb_flag: cover property (lb ##1 delta_r[1] ##1 rd_stat);
  c_read_race: cover property (rd_stat && ev != 3'h0);
  c_irq: cover property ($rose(irq) ##[1:20] wr_ist);
  c_scr: cover property (wr_scr ##1 rd_scr);

endmodule : ums_modem_status

// File: dv/ums_modem_partner.sv
// far-side modem model driving the active-low status pins
`timescale 1ns/1ps

module ums_modem_partner (
  input  wire logic clk,         // bench clock
  input  wire logic slow,        // 1: pins lag the command by four edges
  input  wire logic dcd_cmd,     // 1: assert carrier
  input  wire logic ring_cmd,    // 1: assert ring
  input  wire logic cts_cmd,     // 1: assert clear-to-send
  output logic      dcd_in_low,  // carrier pin
  output logic      ring_in_low, // ring pin
  output logic      cts_in_low   // clear-to-send pin
);
  logic [2:0] lag_r [4] = '{default: 3'h0};
  logic [2:0] act;

  // --------------------------------
  // command pipeline
  // --------------------------------
  // a slow modem settles its lines late; pins idle high like pulled-up lines
  always @(posedge clk) begin
    lag_r[0] <= {dcd_cmd, ring_cmd, cts_cmd};
    for (int i = 1; i < 4; i++) begin
      lag_r[i] <= lag_r[i-1];
    end
  end

  assign act         = slow ? lag_r[3] : lag_r[0];
  assign dcd_in_low  = ~act[2];
  assign ring_in_low = ~act[1];
  assign cts_in_low  = ~act[0];
endmodule : ums_modem_partner

// File: dv/ums_modem_status_tb_top.sv
// self-checking bench for the modem status, control and scratch registers
`timescale 1ns/1ps
`include "ums_regs.svh"

module ums_modem_status_tb_top;
  import ums_pkg::*;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  ums_addr_t   addr = 32'h0000_0000;
  ums_word_t   wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        dcd_in_low;
  logic        ring_in_low;
  logic        cts_in_low;
  logic        rts_out_low;
  logic        user_output_one_low;
  logic        user_output_two_low;
  logic        irq;
  logic        slow = 1'b0;
  logic        dcd_cmd = 1'b1;
  logic        ring_cmd = 1'b0;
  logic        cts_cmd = 1'b1;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  ums_modem_status DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dcd_in_low(dcd_in_low), .ring_in_low(ring_in_low), .cts_in_low(cts_in_low),
    .rts_out_low(rts_out_low), .user_output_one_low(user_output_one_low),
    .user_output_two_low(user_output_two_low), .irq(irq));

  ums_modem_partner modem (.clk(clk), .slow(slow), .dcd_cmd(dcd_cmd), .ring_cmd(ring_cmd),
    .cts_cmd(cts_cmd), .dcd_in_low(dcd_in_low), .ring_in_low(ring_in_low), .cts_in_low(cts_in_low));

  // --------------------------------
  // clock and hang guard
  // --------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      complete_run();
    end
  end

  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task automatic check(input ums_word_t seen, input ums_word_t exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input ums_addr_t a, input ums_word_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input ums_addr_t a, input ums_word_t exp, input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask : rd_chk

  // write, then read in the very next cycle with no gap between strobes
  task automatic wr_rd(input ums_addr_t wa, input ums_word_t d, input ums_addr_t ra, input ums_word_t exp,
                       input string what);
    @(posedge clk);
    addr  <= wa;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ra;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    check(rdata, exp, what);
  endtask : wr_rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic complete_run;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // --------------------------------
  // main sequence
  // --------------------------------
  // carrier and clear-to-send are held asserted through reset
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    settle(6);
    check(ums_word_t'(irq), 16'h0000, "irq_reset");
    rd_chk(`UMS_STAT_OFS, 16'h0099, "held_reset");
    rd_chk(`UMS_STAT_OFS, 16'h0090, "rd_clear");
    rd_chk(`UMS_SCR_OFS, 16'h0000, "scr_rst");
    rd_chk(`UMS_MCTL_OFS, 16'h0000, "mctl_rst");
    dcd_cmd <= 1'b0;
    cts_cmd <= 1'b0;
    settle(8);
    rd_chk(`UMS_STAT_OFS, 16'h0009, "deassert");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "quiet");
    // slow modem on the ring line
    slow     <= 1'b1;
    ring_cmd <= 1'b1;
    settle(10);
    rd_chk(`UMS_STAT_OFS, 16'h0040, "ring_on");
    ring_cmd <= 1'b0;
    settle(10);
    rd_chk(`UMS_STAT_OFS, 16'h0004, "ring_off");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "ring_clr");
    slow <= 1'b0;
    // scratch, reserved bits and an unmapped place
    wr_reg(`UMS_SCR_OFS, 16'hffff);
    rd_chk(`UMS_SCR_OFS, 16'h00ff, "scr_ff");
    wr_reg(`UMS_SCR_OFS, 16'h005a);
    wr_reg(`UMS_STAT_OFS, 16'hffff);
    wr_reg(32'h5000_1010, 16'h0011);
    rd_chk(`UMS_SCR_OFS, 16'h005a, "scr_5a");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "stat_ro");
    rd_chk(32'h5000_1010, 16'h0000, "unmapped");
    wr_rd(`UMS_SCR_OFS, 16'h00a5, `UMS_SCR_OFS, 16'h00a5, "scr_b2b");
    // interrupt: only the ring event is unmasked
    wr_reg(`UMS_IST_OFS, 16'h0007);
    rd_chk(`UMS_IST_OFS, 16'h0000, "ist_clr");
    wr_reg(`UMS_IMSK_OFS, 16'h0002);
    dcd_cmd <= 1'b1;
    settle(8);
    check(ums_word_t'(irq), 16'h0000, "irq_masked");
    rd_chk(`UMS_IST_OFS, 16'h0001, "ist_dcd");
    ring_cmd <= 1'b1;
    settle(8);
    ring_cmd <= 1'b0;
    settle(8);
    check(ums_word_t'(irq), 16'h0001, "irq_ring");
    rd_chk(`UMS_IST_OFS, 16'h0003, "ist_ring");
    wr_reg(`UMS_IST_OFS, 16'h0002);
    settle(2);
    check(ums_word_t'(irq), 16'h0000, "irq_w1c");
    rd_chk(`UMS_IST_OFS, 16'h0001, "ist_left");
    dcd_cmd <= 1'b0;
    settle(8);
    rd_chk(`UMS_STAT_OFS, 16'h000c, "stat_ev");
    wr_reg(`UMS_IST_OFS, 16'h0007);
    // loopback: external carrier ignored, control bits mirrored
    wr_reg(`UMS_MCTL_OFS, 16'h0010);
    dcd_cmd <= 1'b1;
    settle(8);
    check(ums_word_t'({user_output_two_low, user_output_one_low, rts_out_low}), 16'h0007, "pins_loop");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "loop_idle");
    wr_reg(`UMS_MCTL_OFS, 16'h001e);
    settle(2);
    rd_chk(`UMS_STAT_OFS, 16'h00d9, "loop_on");
    wr_reg(`UMS_MCTL_OFS, 16'h0010);
    settle(2);
    check(ums_word_t'(irq), 16'h0001, "irq_loop");
    rd_chk(`UMS_STAT_OFS, 16'h000d, "loop_off");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "loop_clr");
    // a change in the very cycle of the status read must survive the clear
    wr_rd(`UMS_MCTL_OFS, 16'h0018, `UMS_STAT_OFS, 16'h0080, "race_rise");
    rd_chk(`UMS_STAT_OFS, 16'h0088, "race_kept");
    wr_rd(`UMS_MCTL_OFS, 16'h0010, `UMS_STAT_OFS, 16'h0000, "race_fall");
    rd_chk(`UMS_STAT_OFS, 16'h0008, "race_fall_kept");
    dcd_cmd <= 1'b0;
    wr_reg(`UMS_IST_OFS, 16'h0007);
    settle(8);
    wr_reg(`UMS_MCTL_OFS, 16'h0000);
    // control outputs outside loopback, active low
    wr_reg(`UMS_MCTL_OFS, 16'h000e);
    settle(1);
    check(ums_word_t'({user_output_two_low, user_output_one_low, rts_out_low}), 16'h0000, "pins_on");
    rd_chk(`UMS_MCTL_OFS, 16'h000e, "mctl_rw");
    rd_chk(`UMS_STAT_OFS, 16'h0000, "no_mirror");
    wr_reg(`UMS_MCTL_OFS, 16'h0000);
    settle(1);
    check(ums_word_t'({user_output_two_low, user_output_one_low, rts_out_low}), 16'h0007, "pins_off");
    complete_run();
  end
endmodule : ums_modem_status_tb_top
